/* File: ifca_params.svh */
// Offsets, field positions and reset values of the indirect fabric register access block
`ifndef IFCA_PARAMS_SVH
`define IFCA_PARAMS_SVH

`define IFCA_HADDR_W     12
`define IFCA_VAL_OFS     12'h1ac
`define IFCA_CMD_OFS     12'h1b0
`define IFCA_PEND_BIT    31
`define IFCA_DIR_BIT     30
`define IFCA_UP_BIT      29
`define IFCA_DOWN_BIT    28
`define IFCA_LANE_LSB    16
`define IFCA_CMD_RST     32'h0000_0000
`define IFCA_VAL_RST     32'h0000_0000

`endif

/* File: ifca_pkg.sv */
// Types shared by the indirect fabric register access block
package ifca_pkg;

  typedef struct packed {
    logic        pending;
    logic        direction_select;
    logic        step_up_enable;
    logic        step_down_enable;
    logic [7:0]  reserved;
    logic [3:0]  lane_select;
    logic [15:0] target_index;
  } ifca_cmd_t;

  typedef struct packed {
    logic        write;
    logic [3:0]  lane_select;
    logic [15:0] target_index;
    logic [31:0] wdata;
  } ifca_req_t;

endpackage : ifca_pkg

/* File: ifca_fabric_port.sv */
// Request and acknowledge sequencer toward the fabric register space
`timescale 1ns/1ps
`include "ifca_params.svh"

module ifca_fabric_port
  import ifca_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire ifca_req_t   req_i,
  input  wire logic        fab_ack_i,
  input  wire logic [31:0] fab_rdata_i,
  output ifca_req_t        fab_req_data_o,
  output logic             fab_req_o,
  output logic             done_o,
  output logic [31:0]      rdata_o
);

  typedef enum logic [1:0] {
    IFCA_IDLE = 2'b01,
    IFCA_WAIT = 2'b10
  } ifca_port_state_t;

  ifca_port_state_t state_r;
  ifca_port_state_t state_nxt;

  wire take_ack = (state_r == IFCA_WAIT) & fab_ack_i;

  always_comb begin
    case (state_r)
      IFCA_IDLE: state_nxt = start_i ? IFCA_WAIT : IFCA_IDLE;
      IFCA_WAIT: state_nxt = fab_ack_i ? IFCA_IDLE : IFCA_WAIT;
      default:   state_nxt = IFCA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r        <= IFCA_IDLE;
      fab_req_o      <= 1'b0;
      done_o         <= 1'b0;
      rdata_o        <= 32'h0000_0000;
      fab_req_data_o <= '0;
    end else begin
      state_r   <= state_nxt;
      fab_req_o <= (state_nxt == IFCA_WAIT);
      done_o    <= take_ack;
      // Request fields freeze for the whole access so lanes and data stay coherent
      if (start_i && state_r == IFCA_IDLE) begin
        fab_req_data_o <= req_i;
      end
      if (take_ack) begin
        rdata_o <= fab_rdata_i;
      end
    end
  end

endmodule : ifca_fabric_port

/* File: ifca_top.sv */
// Command and value registers of the indirect path into the fabric register space
`timescale 1ns/1ps
`include "ifca_params.svh"

module ifca_top
  import ifca_pkg::*;
(
  input  wire logic [11:0] host_addr_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_rd_i,
  input  wire logic [31:0] host_wdata_i,
  input  wire logic        fab_ack_i,
  input  wire logic [31:0] fab_rdata_i,
  input  wire logic        reset_i,
  input  wire logic        sys_clk_i,
  output logic [31:0]      host_rdata_o,
  output logic             fab_req_o,
  output logic             fab_we_o,
  output logic [3:0]       fab_be_o,
  output logic [15:0]      fab_addr_o,
  output logic [31:0]      fab_wdata_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Step-up has precedence, so a set step-up bit always means plus one
  function automatic logic [15:0] ifca_step(input logic [15:0] idx, input logic up);
    ifca_step = up ? idx + 16'h0001 : idx - 16'h0001;
  endfunction : ifca_step

  ////////////////////////////////////////////////////////////////////////////
  // Host decode

  ifca_cmd_t   cmd_r;
  logic [31:0] wval_r;
  logic [31:0] rval_r;
  ifca_req_t   req;
  ifca_req_t   fab_req_data;
  logic        port_done;
  logic [31:0] port_rdata;

  wire         cmd_hit   = (host_addr_i == `IFCA_CMD_OFS);
  wire         val_hit   = (host_addr_i == `IFCA_VAL_OFS);
  wire         busy      = cmd_r.pending;
  // Accesses that would disturb a running operation are dropped
  wire         cmd_wr    = host_wr_i & cmd_hit & ~busy;
  wire         val_wr    = host_wr_i & val_hit & ~busy;
  wire         val_rd    = host_rd_i & val_hit & ~busy;
  wire         auto_on   = cmd_r.step_up_enable | cmd_r.step_down_enable;
  wire         auto_wr   = val_wr & auto_on;
  wire         auto_rd   = val_rd & auto_on;
  wire         cmd_go    = cmd_wr & host_wdata_i[`IFCA_PEND_BIT];
  wire         start     = cmd_go | auto_wr | auto_rd;
  wire [15:0]  step_idx  = ifca_step(cmd_r.target_index, cmd_r.step_up_enable);
  wire         wr_done   = port_done & ~cmd_r.direction_select & auto_on;
  wire [31:0]  cmd_view  = {cmd_r[31:28], 8'h00, cmd_r[19:0]};
  wire [31:0]  val_view  = cmd_r.direction_select ? rval_r : wval_r;
  wire [31:0]  rd_mux    = cmd_hit ? cmd_view : (val_hit ? val_view : 32'h0000_0000);

  // Request built from the values the register will hold after this cycle
  always_comb begin
    req.write        = cmd_go ? ~host_wdata_i[`IFCA_DIR_BIT] : ~cmd_r.direction_select;
    req.lane_select  = cmd_go ? host_wdata_i[19:16] : cmd_r.lane_select;
    req.target_index = cmd_go ? host_wdata_i[15:0] : (auto_rd ? step_idx : cmd_r.target_index);
    req.wdata        = val_wr ? host_wdata_i : wval_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_r <= `IFCA_CMD_RST;
    end else begin
      if (cmd_wr) begin
        cmd_r          <= host_wdata_i;
        cmd_r.reserved <= 8'h00;
      end
      if (auto_rd) begin
        cmd_r.target_index <= step_idx;
      end else if (wr_done) begin
        cmd_r.target_index <= step_idx;
      end
      // A start in the completion cycle cannot happen: starts need busy low
      if (start) begin
        cmd_r.pending <= 1'b1;
      end else if (port_done) begin
        cmd_r.pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wval_r       <= `IFCA_VAL_RST;
      rval_r       <= `IFCA_VAL_RST;
      host_rdata_o <= 32'h0000_0000;
    end else begin
      if (val_wr) begin
        wval_r <= host_wdata_i;
      end
      if (port_done && cmd_r.direction_select) begin
        rval_r <= port_rdata;
      end
      if (host_rd_i) begin
        host_rdata_o <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fabric side

  ifca_fabric_port u_port (
    .sys_clk_i      (sys_clk_i),
    .reset_i        (reset_i),
    .start_i        (start),
    .req_i          (req),
    .fab_ack_i      (fab_ack_i),
    .fab_rdata_i    (fab_rdata_i),
    .fab_req_data_o (fab_req_data),
    .fab_req_o      (fab_req_o),
    .done_o         (port_done),
    .rdata_o        (port_rdata)
  );

  assign fab_we_o    = fab_req_data.write;
  assign fab_be_o    = fab_req_data.lane_select;
  assign fab_addr_o  = fab_req_data.target_index;
  assign fab_wdata_o = fab_req_data.wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking ck @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_launch;
    start ##1 (busy && fab_req_o);
  endsequence

  sequence s_finish;
    port_done ##1 !busy;
  endsequence

  AST_LAUNCH: assert property (start |-> s_launch)
    else $error("start did not raise pending and fabric request");

  AST_HOLD: assert property (busy && !port_done |=> busy)
    else $error("pending dropped before access finished");

  AST_CLEAR: assert property (port_done |-> s_finish)
    else $error("pending not cleared after access");

  AST_READ_DATA: assert property (
    (port_done && cmd_r.direction_select) |=> (!busy && rval_r == $past(port_rdata)))
    else $error("read cleared pending without captured data");

  AST_DIR: assert property (
    cmd_go |=> (fab_we_o == !$past(host_wdata_i[30])))
    else $error("direction select mapped to wrong access type");

  AST_UP_WRITE: assert property (
    (wr_done && cmd_r.step_up_enable) |=>
      (cmd_r.target_index == $past(cmd_r.target_index) + 16'h0001))
    else $error("index not raised after stepped write");

  AST_DOWN_WRITE: assert property (
    (wr_done && !cmd_r.step_up_enable) |=>
      (cmd_r.target_index == $past(cmd_r.target_index) - 16'h0001))
    else $error("index not lowered after stepped write");

  AST_UP_READ: assert property (
    (auto_rd && cmd_r.step_up_enable) |=>
      (busy && fab_addr_o == $past(cmd_r.target_index) + 16'h0001))
    else $error("stepped read did not raise index");

  AST_DOWN_READ: assert property (
    (auto_rd && !cmd_r.step_up_enable) |=>
      (busy && fab_addr_o == $past(cmd_r.target_index) - 16'h0001))
    else $error("stepped read did not lower index");

  AST_LANES: assert property (fab_req_o |-> (fab_be_o == cmd_r.lane_select))
    else $error("lane select differs from command register");

  AST_INDEX: assert property (fab_req_o |-> (fab_addr_o == cmd_r.target_index))
    else $error("fabric address differs from target index");

  AST_VAL_VIEW: assert property (
    (host_rd_i && val_hit && !cmd_r.direction_select) |=> (host_rdata_o == $past(wval_r)))
    else $error("value read in write mode not last host write");

  AST_WDATA: assert property (
    (fab_req_o && fab_we_o) |-> (fab_wdata_o == wval_r))
    else $error("write data differs from held value");

endmodule : ifca_top

/* File: ifca_fabric_model.sv */
// Behavioural fabric register space answering the indirect access port
`timescale 1ns/1ps

module ifca_fabric_model (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        fab_req_i,
  input  wire logic        fab_we_i,
  input  wire logic [3:0]  fab_be_i,
  input  wire logic [15:0] fab_addr_i,
  input  wire logic [31:0] fab_wdata_i,
  output logic             fab_ack_o,
  output logic [31:0]      fab_rdata_o
);
  logic [31:0] mem [64];
  logic [31:0] rd_r;
  logic [3:0]  cnt_r;
  ////////////////////////////////////////
  // Data is only valid with the ack; otherwise show the inverse to expose early sampling
  assign fab_rdata_o = fab_ack_o ? rd_r : ~rd_r;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fab_ack_o <= 1'b0;
      cnt_r     <= 4'h0;
      rd_r      <= 32'h0000_0000;
      for (int i = 0; i < 64; i++) mem[i] <= 32'h5a00_0000 | i;
    end else if (fab_ack_o) begin
      fab_ack_o <= 1'b0;
      cnt_r     <= 4'h0;
    end else if (fab_req_i) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == lat_i) begin
        fab_ack_o <= 1'b1;
        rd_r      <= mem[fab_addr_i[5:0]];
        for (int b = 0; b < 4; b++) begin
          if (fab_we_i && fab_be_i[b]) mem[fab_addr_i[5:0]][8*b+:8] <= fab_wdata_i[8*b+:8];
        end
      end
    end
  end
endmodule : ifca_fabric_model

/* File: tb_ifca_top.sv */
// Self-checking testbench of the indirect fabric register access block
`timescale 1ns/1ps
`include "ifca_params.svh"

module tb_ifca_top import ifca_pkg::*;;
  logic        sys_clk = 1'b0, reset = 1'b1, hwr = 1'b0, hrd = 1'b0, ack, req, we;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, frdata, fwdata;
  logic [3:0]  be, lat = 4'h0;
  logic [15:0] faddr;
  int          n_mismatch = 0, num_checks = 0;
  localparam logic [11:0] CMD = `IFCA_CMD_OFS;
  localparam logic [11:0] VAL = `IFCA_VAL_OFS;
  always #12.5 sys_clk = ~sys_clk;
  ifca_top uut (.host_addr_i(haddr), .host_wr_i(hwr), .host_rd_i(hrd), .host_wdata_i(hwdata),
    .fab_ack_i(ack), .fab_rdata_i(frdata), .reset_i(reset), .sys_clk_i(sys_clk),
    .host_rdata_o(hrdata), .fab_req_o(req), .fab_we_o(we), .fab_be_o(be),
    .fab_addr_o(faddr), .fab_wdata_o(fwdata));
  ifca_fabric_model fab (.sys_clk_i(sys_clk), .reset_i(reset), .lat_i(lat), .fab_req_i(req),
    .fab_we_i(we), .fab_be_i(be), .fab_addr_i(faddr), .fab_wdata_i(fwdata),
    .fab_ack_o(ack), .fab_rdata_o(frdata));
  ////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    haddr = a;
    hwdata = d;
    hwr = 1'b1;
    @(negedge sys_clk);
    hwr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge sys_clk);
    haddr = a;
    hrd = 1'b1;
    @(negedge sys_clk);
    hrd = 1'b0;
    d = hrdata;
  endtask : rd
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdchk
  // Poll the pending flag before touching the registers again
  task automatic idle;
    logic [31:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(CMD, d);
      if (d[31] === 1'b0) return;
    end
    n_mismatch++;
    $display("MISMATCH %0t pending never cleared", $time);
  endtask : idle
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    rdchk(CMD, `IFCA_CMD_RST);
    rdchk(VAL, `IFCA_VAL_RST);
    rdchk(12'h000, 32'h0000_0000);
    wr(CMD, 32'h0ff3_0007);
    chk({31'h0, req}, 32'h0000_0000);
    rdchk(CMD, 32'h0003_0007);
    chk(fab.mem[7], 32'h5a00_0007);
    lat = 4'h3;
    wr(VAL, 32'h1122_3344);
    wr(CMD, 32'h8005_0005);
    chk({31'h0, req}, 32'h0000_0001);
    rdchk(CMD, 32'h8005_0005);
    idle();
    chk(fab.mem[5], 32'h5a22_0044);
    rdchk(VAL, 32'h1122_3344);
    lat = 4'h5;
    wr(CMD, 32'hc00f_0005);
    // Deliberately break the host rule: the device must drop this write
    wr(CMD, 32'h0000_0000);
    idle();
    rdchk(VAL, 32'h5a22_0044);
    rdchk(CMD, 32'h400f_0005);
    wr(CMD, 32'he00f_0008);
    idle();
    rdchk(VAL, 32'h5a00_0008);
    idle();
    rdchk(CMD, 32'h600f_0009);
    wr(CMD, 32'h400f_0009);
    rdchk(VAL, 32'h5a00_0009);
    rdchk(CMD, 32'h400f_0009);
    wr(CMD, 32'hf00f_0014);
    idle();
    rdchk(VAL, 32'h5a00_0014);
    idle();
    rdchk(CMD, 32'h700f_0015);
    wr(CMD, 32'hd00f_0014);
    idle();
    rdchk(VAL, 32'h5a00_0014);
    idle();
    rdchk(CMD, 32'h500f_0013);
    lat = 4'h0;
    wr(CMD, 32'h200f_0030);
    wr(VAL, 32'hcafe_0001);
    idle();
    chk(fab.mem[48], 32'hcafe_0001);
    rdchk(CMD, 32'h200f_0031);
    wr(CMD, 32'h100f_0000);
    wr(VAL, 32'hbeef_0002);
    idle();
    chk(fab.mem[0], 32'hbeef_0002);
    rdchk(CMD, 32'h100f_ffff);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
endmodule : tb_ifca_top
